// >>> rtl/dic_defs.svh
// register offsets, field positions, reset values and timing counts
`ifndef DIC_DEFS_SVH
`define DIC_DEFS_SVH

// register byte offsets on the plain register port
`define DIC_OFS_CTRL      8'h00
`define DIC_OFS_DEBOUNCE  8'h04
`define DIC_OFS_STATE     8'h08
`define DIC_OFS_COUNT     8'h0C
`define DIC_OFS_IRQ_STAT  8'h10
`define DIC_OFS_IRQ_MASK  8'h14

// control register fields
`define DIC_CTRL_MODE_LSB 0
`define DIC_CTRL_MODE_MSB 1
`define DIC_CTRL_INV_BIT  2
`define DIC_CTRL_CSRC_BIT 3
`define DIC_CTRL_ASGN_BIT 4

// state register fields
`define DIC_ST_STATE_BIT  0
`define DIC_ST_DEB_BIT    1
`define DIC_ST_AC_BIT     2
`define DIC_ST_TC_BIT     3

// interrupt status and mask fields
`define DIC_IRQ_COUNT_BIT 0
`define DIC_IRQ_STATE_BIT 1

// reset values
`define DIC_RST_INVERT    1'h0
`define DIC_RST_CSRC      1'h0
`define DIC_RST_ASSIGN    1'h0
`define DIC_RST_DEB_MS    10'h000
`define DIC_RST_MASK      2'h0

// timing: clock rate in MHz, debounce ceiling and AC hold in ms
`define DIC_CLK_MHZ       100
`define DIC_CLK_PER_MS    (`DIC_CLK_MHZ * 1000)
`define DIC_DEB_MAX_MS    10'h3E8
`define DIC_AC_HOLD_MS    8'h19

`endif

// >>> rtl/dic_pkg.sv
// types shared by the input conditioner files
package dic_pkg;

    // channel operating modes
    typedef enum logic [1:0] {
        dic_mode_pulse,
        dic_transition_count_mode,
        dic_mode_ac,
        dic_mode_timecode
    } dic_mode_type;

endpackage

// >>> rtl/dic_debounce.sv
// debounce filter: accepts a level once it has stood long enough
`timescale 1ns/10ps
`include "dic_defs.svh"

module dic_debounce #(
    parameter int CLK_PER_MS = `DIC_CLK_PER_MS,
    parameter int CNT_W      = 27,
    parameter int MS_W       = 10
) (
    input  wire logic            clk,
    input  wire logic            srst,
    input  wire logic            level_in,
    input  wire logic [MS_W-1:0] deb_ms,
    output logic                 level_out,
    output logic                 changed
);

    logic             prev_reg;
    logic             acc_reg;
    logic             chg_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] target;

    // interval in ms turned into clock cycles
    function automatic logic [CNT_W-1:0] ms_to_cycles(
        input logic [MS_W-1:0] ms
    );
        ms_to_cycles = CNT_W'(64'(ms) * 64'(CLK_PER_MS));
    endfunction

    assign target    = ms_to_cycles(deb_ms);
    assign level_out = acc_reg;
    assign changed   = chg_reg;

    // previous sample, used to spot a level that moved again
    always_ff @(posedge clk) begin
        if (srst) begin
            prev_reg <= 1'h0;
        end else begin
            prev_reg <= level_in;
        end
    end

    // stability counter; any bounce restarts it from one
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_reg <= '0;
            acc_reg <= 1'h0;
            chg_reg <= 1'h0;
        end else begin
            chg_reg <= 1'h0;
            if (level_in == acc_reg) begin
                cnt_reg <= '0;
            end else if (level_in != prev_reg) begin
                cnt_reg <= CNT_W'(1);
            end else if (cnt_reg >= target) begin
                acc_reg <= level_in;
                chg_reg <= 1'h1;
                cnt_reg <= '0;
            end else begin
                cnt_reg <= cnt_reg + CNT_W'(1);
            end
        end
    end

    default clocking dc @(posedge clk); endclocking
    default disable iff (srst);

    property p_accept_after_hold;
        $changed(acc_reg) |-> $past(cnt_reg >= target);
    endproperty
    a_accept_after_hold: assert property (p_accept_after_hold)
        else $error("level accepted before debounce time");

    property p_restart_on_bounce;
        (level_in != prev_reg && level_in != acc_reg)
            |=> (cnt_reg == CNT_W'(1)) && $stable(acc_reg);
    endproperty
    a_restart_on_bounce: assert property (p_restart_on_bounce)
        else $error("debounce count not restarted on change");

endmodule

// >>> rtl/dic_channel.sv
// one conditioned digital input channel with its register port
`timescale 1ns/10ps
`include "dic_defs.svh"

module dic_channel #(
    parameter int   CLK_PER_MS = `DIC_CLK_PER_MS,
    parameter int   CNT_W      = 27,
    parameter int   COUNT_W    = 32,
    parameter bit   ON_BASE    = 1'b1,
    parameter logic [7:0] AC_HOLD_MS = `DIC_AC_HOLD_MS
) (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        din,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [31:0] rdata,
    output logic             irq,
    output logic             contact_state,
    output logic             meter_pulse,
    output logic             timecode_out,
    output logic             timecode_sync_en
);

    localparam int MS_W = 10;

    dic_pkg::dic_mode_type mode_reg;
    dic_pkg::dic_mode_type wr_mode;
    logic                  invert_reg;
    logic                  clksrc_reg;
    logic                  assign_reg;
    logic [MS_W-1:0]       deb_ms_reg;
    logic                  cond;
    logic                  deb_level;
    logic                  deb_chg;
    logic [CNT_W-1:0]      ms_div_reg;
    logic                  ms_tick_reg;
    logic                  cond_prev_reg;
    logic [7:0]            ac_cnt_reg;
    logic                  ac_on_reg;
    logic                  armed_reg;
    logic                  count_evt;
    logic [COUNT_W-1:0]    count_reg;
    logic                  state_next;
    logic                  state_reg;
    logic                  meter_reg;
    logic                  tc_path;
    logic                  tc_out_reg;
    logic                  tc_en_reg;
    logic [1:0]            irq_stat_reg;
    logic [1:0]            irq_mask_reg;
    logic [1:0]            irq_evt;
    logic                  irq_reg;
    logic [31:0]           rd_value;
    logic [31:0]           rdata_reg;
    logic                  ctrl_wr;
    logic                  deb_wr;
    logic                  cnt_wr;
    logic                  stat_wr;
    logic                  mask_wr;

    // register write decode
    assign ctrl_wr = wr_en && (addr == `DIC_OFS_CTRL);
    assign deb_wr  = wr_en && (addr == `DIC_OFS_DEBOUNCE);
    assign cnt_wr  = wr_en && (addr == `DIC_OFS_COUNT);
    assign stat_wr = wr_en && (addr == `DIC_OFS_IRQ_STAT);
    assign mask_wr = wr_en && (addr == `DIC_OFS_IRQ_MASK);

    assign wr_mode = dic_pkg::dic_mode_type'(
        wdata[`DIC_CTRL_MODE_MSB:`DIC_CTRL_MODE_LSB]);

    // control register; an option-module channel keeps its old mode
    // when asked for time-code, other fields still take the write
    always_ff @(posedge clk) begin
        if (srst) begin
            mode_reg   <= dic_pkg::dic_mode_pulse;
            invert_reg <= `DIC_RST_INVERT;
            clksrc_reg <= `DIC_RST_CSRC;
            assign_reg <= `DIC_RST_ASSIGN;
        end else if (ctrl_wr) begin
            if (ON_BASE || wr_mode != dic_pkg::dic_mode_timecode) begin
                mode_reg <= wr_mode;
            end
            invert_reg <= wdata[`DIC_CTRL_INV_BIT];
            clksrc_reg <= wdata[`DIC_CTRL_CSRC_BIT];
            assign_reg <= wdata[`DIC_CTRL_ASGN_BIT];
        end
    end

    // debounce interval in ms, clamped to the one second ceiling
    always_ff @(posedge clk) begin
        if (srst) begin
            deb_ms_reg <= `DIC_RST_DEB_MS;
        end else if (deb_wr) begin
            if (wdata > {22'h000000, `DIC_DEB_MAX_MS}) begin
                deb_ms_reg <= `DIC_DEB_MAX_MS;
            end else begin
                deb_ms_reg <= wdata[MS_W-1:0];
            end
        end
    end

    // polarity applied before anything else looks at the pin
    assign cond = din ^ invert_reg;

    dic_debounce #(
        .CLK_PER_MS (CLK_PER_MS),
        .CNT_W      (CNT_W),
        .MS_W       (MS_W)
    ) u_debounce (
        .clk       (clk),
        .srst      (srst),
        .level_in  (cond),
        .deb_ms    (deb_ms_reg),
        .level_out (deb_level),
        .changed   (deb_chg)
    );

    // free-running millisecond enable for the AC presence timer
    always_ff @(posedge clk) begin
        if (srst) begin
            ms_div_reg  <= '0;
            ms_tick_reg <= 1'h0;
        end else if (ms_div_reg == CNT_W'(CLK_PER_MS - 1)) begin
            ms_div_reg  <= '0;
            ms_tick_reg <= 1'h1;
        end else begin
            ms_div_reg  <= ms_div_reg + CNT_W'(1);
            ms_tick_reg <= 1'h0;
        end
    end

    // AC presence: any raw edge re-arms the hold timer; the raw level
    // is used because debounce would swallow the alternating signal
    always_ff @(posedge clk) begin
        if (srst) begin
            cond_prev_reg <= 1'h0;
            ac_cnt_reg    <= 8'h00;
            ac_on_reg     <= 1'h0;
        end else begin
            cond_prev_reg <= cond;
            if (cond != cond_prev_reg) begin
                ac_cnt_reg <= 8'h00;
                ac_on_reg  <= 1'h1;
            end else if (ms_tick_reg && ac_on_reg) begin
                if (ac_cnt_reg == AC_HOLD_MS - 8'h01) begin
                    ac_on_reg <= 1'h0;
                end else begin
                    ac_cnt_reg <= ac_cnt_reg + 8'h01;
                end
            end
        end
    end

    // half a pulse seen: set on accepted rise, cleared on fall
    always_ff @(posedge clk) begin
        if (srst) begin
            armed_reg <= 1'h0;
        end else if (mode_reg != dic_pkg::dic_mode_pulse) begin
            armed_reg <= 1'h0;
        end else if (deb_chg) begin
            armed_reg <= deb_level;
        end
    end

    // count event per mode; AC and time-code never count
    always_comb begin
        count_evt = 1'h0;
        case (mode_reg)
            dic_pkg::dic_mode_pulse: begin
                count_evt = deb_chg && !deb_level && armed_reg;
            end
            dic_pkg::dic_transition_count_mode: begin
                count_evt = deb_chg;
            end
            default: begin
                count_evt = 1'h0;
            end
        endcase
    end

    // pulse counter; a write clears it but a same-cycle event survives
    always_ff @(posedge clk) begin
        if (srst) begin
            count_reg <= '0;
        end else if (cnt_wr) begin
            count_reg <= count_evt ? COUNT_W'(1) : '0;
        end else if (count_evt) begin
            count_reg <= count_reg + COUNT_W'(1);
        end
    end

    // one-cycle pulse to the metering channel when assigned
    always_ff @(posedge clk) begin
        if (srst) begin
            meter_reg <= 1'h0;
        end else begin
            meter_reg <= count_evt && assign_reg;
        end
    end

    // reported contact state per mode
    always_comb begin
        state_next = deb_level;
        case (mode_reg)
            dic_pkg::dic_mode_ac: begin
                state_next = ac_on_reg;
            end
            dic_pkg::dic_mode_timecode: begin
                state_next = cond;
            end
            default: begin
                state_next = deb_level;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= 1'h0;
        end else begin
            state_reg <= state_next;
        end
    end

    // time-code path: only with both mode and clock source set,
    // passed without debounce so edge timing stays intact
    assign tc_path = (mode_reg == dic_pkg::dic_mode_timecode)
                     && clksrc_reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            tc_out_reg <= 1'h0;
            tc_en_reg  <= 1'h0;
        end else begin
            tc_out_reg <= tc_path ? cond : 1'h0;
            tc_en_reg  <= tc_path;
        end
    end

    // interrupt status: events set, write one clears, set wins
    assign irq_evt[`DIC_IRQ_COUNT_BIT] = count_evt;
    assign irq_evt[`DIC_IRQ_STATE_BIT] = state_next != state_reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            irq_stat_reg <= 2'h0;
        end else if (stat_wr) begin
            irq_stat_reg <= (irq_stat_reg & ~wdata[1:0]) | irq_evt;
        end else begin
            irq_stat_reg <= irq_stat_reg | irq_evt;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            irq_mask_reg <= `DIC_RST_MASK;
        end else if (mask_wr) begin
            irq_mask_reg <= wdata[1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            irq_reg <= 1'h0;
        end else begin
            irq_reg <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // read mux; unmapped addresses read as zero
    always_comb begin
        rd_value = 32'h00000000;
        case (addr)
            `DIC_OFS_CTRL: begin
                rd_value[`DIC_CTRL_MODE_MSB:`DIC_CTRL_MODE_LSB] = mode_reg;
                rd_value[`DIC_CTRL_INV_BIT]  = invert_reg;
                rd_value[`DIC_CTRL_CSRC_BIT] = clksrc_reg;
                rd_value[`DIC_CTRL_ASGN_BIT] = assign_reg;
            end
            `DIC_OFS_DEBOUNCE: begin
                rd_value[MS_W-1:0] = deb_ms_reg;
            end
            `DIC_OFS_STATE: begin
                rd_value[`DIC_ST_STATE_BIT] = state_reg;
                rd_value[`DIC_ST_DEB_BIT]   = deb_level;
                rd_value[`DIC_ST_AC_BIT]    = ac_on_reg;
                rd_value[`DIC_ST_TC_BIT]    = tc_en_reg;
            end
            `DIC_OFS_COUNT: begin
                rd_value = 32'(count_reg);
            end
            `DIC_OFS_IRQ_STAT: begin
                rd_value[1:0] = irq_stat_reg;
            end
            `DIC_OFS_IRQ_MASK: begin
                rd_value[1:0] = irq_mask_reg;
            end
            default: begin
                rd_value = 32'h00000000;
            end
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_reg <= 32'h00000000;
        end else begin
            rdata_reg <= rd_en ? rd_value : 32'h00000000;
        end
    end

    assign rdata            = rdata_reg;
    assign irq              = irq_reg;
    assign contact_state    = state_reg;
    assign meter_pulse      = meter_reg;
    assign timecode_out     = tc_out_reg;
    assign timecode_sync_en = tc_en_reg;

    default clocking dc @(posedge clk); endclocking
    default disable iff (srst);

    property p_pulse_full;
        (mode_reg == dic_pkg::dic_mode_pulse && deb_chg && !deb_level
            && armed_reg && !cnt_wr)
            |=> count_reg == $past(count_reg) + COUNT_W'(1);
    endproperty
    a_pulse_full: assert property (p_pulse_full)
        else $error("full pulse not counted");

    property p_pulse_half;
        (mode_reg == dic_pkg::dic_mode_pulse && deb_chg && deb_level
            && !cnt_wr) |=> $stable(count_reg);
    endproperty
    a_pulse_half: assert property (p_pulse_half)
        else $error("rising edge alone counted in pulse mode");

    property p_trans_count;
        (mode_reg == dic_pkg::dic_transition_count_mode && deb_chg
            && !cnt_wr) |=> count_reg == $past(count_reg) + COUNT_W'(1);
    endproperty
    a_trans_count: assert property (p_trans_count)
        else $error("transition not counted");

    property p_ac_state;
        (mode_reg == dic_pkg::dic_mode_ac && $changed(cond))
            |=> ##1 contact_state;
    endproperty
    a_ac_state: assert property (p_ac_state)
        else $error("AC presence not reported");

    property p_tc_follow;
        timecode_sync_en |-> timecode_out == $past(din ^ invert_reg);
    endproperty
    a_tc_follow: assert property (p_tc_follow)
        else $error("time-code output does not follow input");

    property p_tc_gate;
        timecode_sync_en |-> $past(mode_reg == dic_pkg::dic_mode_timecode
                                   && clksrc_reg);
    endproperty
    a_tc_gate: assert property (p_tc_gate)
        else $error("time sync active without both settings");

    property p_no_tc_option;
        !ON_BASE |-> mode_reg != dic_pkg::dic_mode_timecode;
    endproperty
    a_no_tc_option: assert property (p_no_tc_option)
        else $error("option channel entered time-code mode");

    property p_meter_pulse;
        meter_pulse |-> $past(assign_reg && deb_chg) ##1 !meter_pulse
            || $past(deb_chg, 1) && deb_chg;
    endproperty
    a_meter_pulse: assert property (p_meter_pulse)
        else $error("metering pulse without assigned count");

    property p_status_deb;
        (mode_reg == dic_pkg::dic_transition_count_mode)
            |=> contact_state == $past(deb_level);
    endproperty
    a_status_deb: assert property (p_status_deb)
        else $error("status does not show debounced level");

endmodule

// >>> tb/dic_contact_model.sv
// behavioural external contact or pulse source on the raw input pin
`timescale 1ns/10ps

module dic_contact_model (
    input  wire logic clk,
    output logic      din
);
    // open contact reads low through the input pull-down
    initial din = 1'b0;

    // a contact only moves just after a rising edge
    task automatic set_level(input logic v);
        @(posedge clk);
        din <= v;
    endtask

    // bounce: an excursion shorter than the filter must not be accepted
    task automatic glitch(input int n);
        set_level(~din);
        repeat (n) @(posedge clk);
        din <= ~din;
    endtask

    // alternating source for presence detection, half period in cycles
    task automatic ac_burst(input int edges, input int half);
        for (int i = 0; i < edges; i++) begin
            repeat (half) @(posedge clk);
            din <= ~din;
        end
    endtask
endmodule

// >>> tb/tb_top.sv
// self-checking bench for two conditioned digital input channels, base and option module
`timescale 1ns/10ps
`include "dic_defs.svh"

`define CHK(got, exp) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) begin \
            fails++; \
            $display("unexpected at %0t: got %h expected %h", \
                     $time, (got), (exp)); \
        end \
    end

module tb_top;
    logic        clk;
    logic        srst;
    logic        din;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr_en;
    logic        rd_en;
    logic [31:0] rdata;
    logic [31:0] rdata_opt;
    logic [4:0]  opt_o;
    logic        irq;
    logic        contact_state;
    logic        meter_pulse;
    logic        timecode_out;
    logic        timecode_sync_en;
    logic [31:0] d;
    logic [31:0] e;
    int          fails = 0;
    int          num_checks = 0;
    int          pulses = 0;
    int          pulses_opt = 0;
    int          p0;
    logic [7:0]  ofs [7] = '{`DIC_OFS_CTRL, `DIC_OFS_DEBOUNCE,
                            `DIC_OFS_STATE, `DIC_OFS_COUNT,
                            `DIC_OFS_IRQ_STAT, `DIC_OFS_IRQ_MASK, 8'h20};

    // 1 ms is 10 cycles so debounce and presence times stay short
    dic_channel #(.CLK_PER_MS(10)) dic_channel_i (
        .clk(clk), .srst(srst), .din(din), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq(irq),
        .contact_state(contact_state), .meter_pulse(meter_pulse),
        .timecode_out(timecode_out), .timecode_sync_en(timecode_sync_en)
    );

    // option-module channel shares bus and pin; it must refuse time code
    dic_channel #(.CLK_PER_MS(10), .ON_BASE(1'b0)) dic_channel_opt_i (
        .clk(clk), .srst(srst), .din(din), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata_opt), .irq(opt_o[0]),
        .contact_state(opt_o[1]), .meter_pulse(opt_o[2]),
        .timecode_out(opt_o[3]), .timecode_sync_en(opt_o[4])
    );

    dic_contact_model dic_contact_model_i (.clk(clk), .din(din));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // tally metering pulses of each channel, counted apart
    always @(posedge clk) begin
        if (meter_pulse === 1'b1) begin
            pulses <= pulses + 1;
        end
        if (opt_o[2] === 1'b1) begin
            pulses_opt <= pulses_opt + 1;
        end
    end

    function automatic logic [31:0] ctrl(input dic_pkg::dic_mode_type m,
                                         input int inv, input int cs,
                                         input int asg);
        return {27'h0, 1'(asg), 1'(cs), 1'(inv), m};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] v,
                      output logic [31:0] vo);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        v  = rdata;
        vo = rdata_opt;
    endtask

    task automatic wait_cs(input logic v, input int lim);
        int n = 0;
        while (contact_state !== v && n < lim) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (contact_state !== v) begin
            fails++;
            summarize();
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // a hang anywhere ends the run as a mismatch
    initial begin
        #100us;
        fails++;
        summarize();
    end

    initial begin
        srst  = 1'b1;
        addr  = 8'h00;
        wdata = 32'h0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        // every register clears at reset, unmapped place reads zero
        foreach (ofs[i]) begin
            rd(ofs[i], d, e);
            `CHK(d, 32'h0);
        end
        wr(`DIC_OFS_DEBOUNCE, 32'h7D0);
        rd(`DIC_OFS_DEBOUNCE, d, e);
        `CHK(d, 32'h3E8);
        wr(`DIC_OFS_DEBOUNCE, 32'h0);
        // each accepted change counts and pulses the metering side
        wr(`DIC_OFS_IRQ_MASK, 32'h3);
        wr(`DIC_OFS_CTRL, ctrl(dic_pkg::dic_transition_count_mode, 0, 0, 1));
        p0 = pulses;
        dic_contact_model_i.set_level(1'b1);
        wait_cs(1'b1, 20);
        rd(`DIC_OFS_COUNT, d, e);
        `CHK(d, 32'h1);
        dic_contact_model_i.set_level(1'b0);
        wait_cs(1'b0, 20);
        rd(`DIC_OFS_COUNT, d, e);
        `CHK(d, 32'h2);
        `CHK(pulses - p0, 2);
        `CHK(pulses_opt, 2);
        `CHK(irq, 1'b1);
        `CHK(opt_o[0], 1'b1);
        rd(`DIC_OFS_IRQ_STAT, d, e);
        `CHK(d, 32'h3);
        `CHK(e, 32'h3);
        wr(`DIC_OFS_IRQ_STAT, 32'h3);
        repeat (2) @(posedge clk);
        #1;
        `CHK(irq, 1'b0);
        // unassigned and masked: status sets, no pulse, no interrupt
        wr(`DIC_OFS_IRQ_MASK, 32'h0);
        wr(`DIC_OFS_CTRL, ctrl(dic_pkg::dic_transition_count_mode, 0, 0, 0));
        dic_contact_model_i.set_level(1'b1);
        wait_cs(1'b1, 20);
        repeat (2) @(posedge clk);
        #1;
        `CHK(pulses - p0, 2);
        `CHK(pulses_opt, 2);
        `CHK(irq, 1'b0);
        rd(`DIC_OFS_IRQ_STAT, d, e);
        `CHK(d, 32'h3);
        wr(`DIC_OFS_IRQ_MASK, 32'h1);
        repeat (2) @(posedge clk);
        #1;
        `CHK(irq, 1'b1);
        `CHK(opt_o[0], 1'b1);
        wr(`DIC_OFS_IRQ_STAT, 32'h3);
        dic_contact_model_i.set_level(1'b0);
        wait_cs(1'b0, 20);
        // full pulse: a rise alone adds nothing
        wr(`DIC_OFS_COUNT, 32'h0);
        wr(`DIC_OFS_CTRL, ctrl(dic_pkg::dic_mode_pulse, 0, 0, 0));
        dic_contact_model_i.set_level(1'b1);
        wait_cs(1'b1, 20);
        rd(`DIC_OFS_COUNT, d, e);
        `CHK(d, 32'h0);
        dic_contact_model_i.set_level(1'b0);
        wait_cs(1'b0, 20);
        rd(`DIC_OFS_COUNT, d, e);
        `CHK(d, 32'h1);
        // inverted polarity turns an open contact into ON
        wr(`DIC_OFS_CTRL, ctrl(dic_pkg::dic_mode_pulse, 1, 0, 0));
        wait_cs(1'b1, 20);
        rd(`DIC_OFS_STATE, d, e);
        `CHK(d[`DIC_ST_STATE_BIT], 1'b1);
        `CHK(opt_o[1], 1'b1);
        wr(`DIC_OFS_CTRL, ctrl(dic_pkg::dic_mode_pulse, 0, 0, 0));
        wait_cs(1'b0, 20);
        // 1 ms filter: a bounce is dropped, a steady level waits it out
        wr(`DIC_OFS_DEBOUNCE, 32'h1);
        dic_contact_model_i.glitch(5);
        repeat (25) @(posedge clk);
        #1;
        `CHK(contact_state, 1'b0);
        dic_contact_model_i.set_level(1'b1);
        repeat (8) @(posedge clk);
        #1;
        `CHK(contact_state, 1'b0);
        wait_cs(1'b1, 10);
        wr(`DIC_OFS_DEBOUNCE, 32'h0);
        dic_contact_model_i.set_level(1'b0);
        wait_cs(1'b0, 20);
        // presence of alternation is ON, it drops after the hold time
        wr(`DIC_OFS_CTRL, ctrl(dic_pkg::dic_mode_ac, 0, 0, 0));
        dic_contact_model_i.ac_burst(20, 4);
        rd(`DIC_OFS_STATE, d, e);
        `CHK(d[`DIC_ST_AC_BIT], 1'b1);
        `CHK(contact_state, 1'b1);
        repeat (200) @(posedge clk);
        #1;
        `CHK(contact_state, 1'b1);
        wait_cs(1'b0, 100);
        // time code needs both the mode and the clock source
        rd(`DIC_OFS_COUNT, p0, e);
        wr(`DIC_OFS_CTRL, ctrl(dic_pkg::dic_mode_timecode, 0, 0, 0));
        repeat (2) @(posedge clk);
        #1;
        `CHK(timecode_sync_en, 1'b0);
        wr(`DIC_OFS_CTRL, ctrl(dic_pkg::dic_mode_timecode, 0, 1, 0));
        rd(`DIC_OFS_CTRL, d, e);
        `CHK(d, ctrl(dic_pkg::dic_mode_timecode, 0, 1, 0));
        `CHK(e, ctrl(dic_pkg::dic_mode_ac, 0, 1, 0));
        `CHK(timecode_sync_en, 1'b1);
        `CHK(opt_o[4:3], 2'b00);
        for (int i = 0; i < 2; i++) begin
            dic_contact_model_i.set_level(~din);
            repeat (2) @(posedge clk);
            #1;
            `CHK(timecode_out, din);
        end
        rd(`DIC_OFS_COUNT, d, e);
        `CHK(d, p0);
        summarize();
    end
endmodule
